// ===== design/dps_pkg.sv
package dps_pkg;

    // ------------------------------------------------------------------
    // Bus and array sizes
    // ------------------------------------------------------------------
    localparam int          ADDR_W = 8;
    localparam int          NPAR   = 8;
    localparam int          DO_N   = 6;
    localparam int          DI_N   = 10;

    // ------------------------------------------------------------------
    // Register byte offsets and address regions
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_OUT_INVERT_MASK = 8'h00;
    localparam logic [7:0]  OFS_INPUT_SIM_SELECT = 8'h04;
    localparam logic [7:0]  OFS_INPUT_SIM_VALUE = 8'h08;
    localparam logic [7:0]  OFS_DRIVE_STATUS    = 8'h0c;
    localparam logic [2:0]  REGION_PARAM_STORED = 3'h2;  // 0x40..0x5f
    localparam logic [2:0]  REGION_PARAM_ACTIVE = 3'h3;  // 0x60..0x7f
    localparam logic [2:0]  REGION_PARAM_INFO   = 3'h4;  // 0x80..0x9f

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [5:0]  OUT_INVERT_RST      = 6'h00;
    localparam logic [9:0]  SIM_SELECT_RST      = 10'h000;
    localparam logic [9:0]  SIM_VALUE_RST       = 10'h000;
    localparam int          STAT_RUNNING_BIT    = 0;
    localparam int          STAT_READY_BIT      = 1;
    localparam int          STAT_REJECT_LSB     = 16;
    localparam int          INFO_RO_BIT         = 0;
    localparam int          INFO_RE_BIT         = 1;
    localparam int          INFO_RUN_BIT        = 2;
    localparam int          INFO_RDY_BIT        = 3;
    localparam int          INFO_TYPE_LSB       = 4;
    localparam int          INFO_GROUP_LSB      = 8;

    // ------------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_SLVERR         = 2'h2;

    // ------------------------------------------------------------------
    // Data types and groups
    // ------------------------------------------------------------------
    localparam logic [2:0]  TYPE_SIGNED_16      = 3'h0;
    localparam logic [2:0]  TYPE_SIGNED_32      = 3'h1;
    localparam logic [2:0]  TYPE_UNSIGNED_8     = 3'h2;
    localparam logic [2:0]  TYPE_UNSIGNED_16    = 3'h3;
    localparam logic [2:0]  TYPE_UNSIGNED_32    = 3'h4;
    localparam logic [2:0]  TYPE_FLOAT_32       = 3'h5;
    localparam logic [2:0]  GRP_BASIC = 3'h0, GRP_GAIN = 3'h1, GRP_SPEED = 3'h2, GRP_TORQUE = 3'h3;
    localparam logic [2:0]  GRP_POSITION = 3'h4, GRP_IO = 3'h5, GRP_STATUS = 3'h6;

    // ------------------------------------------------------------------
    // Parameter table attributes, entry 7 leftmost
    // ------------------------------------------------------------------
    localparam logic [NPAR-1:0]       PAR_READ_ONLY    = 8'hc0;
    localparam logic [NPAR-1:0]       PAR_POWER_CYCLE  = 8'h14;
    localparam logic [NPAR-1:0]       PAR_CHG_RUN      = 8'h33;
    localparam logic [NPAR-1:0]       PAR_CHG_READY    = 8'h3d;
    localparam logic [NPAR-1:0][2:0]  PAR_TYPE  = {TYPE_UNSIGNED_32, TYPE_FLOAT_32, TYPE_UNSIGNED_32,
        TYPE_UNSIGNED_8, TYPE_SIGNED_16, TYPE_UNSIGNED_32, TYPE_SIGNED_32, TYPE_UNSIGNED_16};
    localparam logic [NPAR-1:0][2:0]  PAR_GROUP = {GRP_STATUS, GRP_STATUS, GRP_IO, GRP_POSITION,
        GRP_TORQUE, GRP_SPEED, GRP_GAIN, GRP_BASIC};
    localparam logic [NPAR-1:0][31:0] PAR_DEFAULT = {32'h0000_0000, 32'h0000_0000, 32'h0000_0010,
        32'h0000_0001, 32'h0000_0064, 32'h0000_07d0, 32'h0000_000f, 32'h0000_0000};

endpackage

// ===== design/dps_param_store.sv
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dps_param_store
    import dps_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   drive_running,
    input  wire logic                   drive_ready,
    input  wire logic                   power_on_load,
    input  wire logic [DI_N-1:0]        safe_torque_off_src,
    input  wire logic [DI_N-1:0]        input_line_pin,
    output var  logic [DI_N-1:0]        input_line_func,
    input  wire logic [DO_N-1:0]        output_line_func,
    output var  logic [DO_N-1:0]        output_line_pin,
    output var  logic [NPAR*32-1:0]     param_value
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    aw_got;
        logic [ADDR_W-1:0]       aw_addr;
        logic                    w_got;
        logic [31:0]             w_data;
        logic [3:0]              w_strb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic [5:0]              out_invert_mask;
        logic [9:0]              input_sim_select;
        logic [9:0]              input_sim_value;
        logic [NPAR-1:0][31:0]   stored;
        logic [NPAR-1:0][31:0]   active;
        logic [15:0]             reject_cnt;
        logic [DO_N-1:0]         do_out;
        logic [DI_N-1:0]         di_eff;
    } dps_state_type;

    dps_state_type           s_q;
    dps_state_type           s_d;
    logic                    wr_do;
    logic                    wr_ok;
    logic [2:0]              wr_idx;
    logic [2:0]              wr_region;
    logic [31:0]             wr_bmask;
    logic [31:0]             wr_old;
    logic [31:0]             wr_merged;
    logic                    fix_chg;
    logic [DI_N-1:0]         sim_eff;
    logic [32:0]             wr_look;
    logic [32:0]             rd_look;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Narrow types are cut and extended so the stored word is always legal
    function automatic logic [31:0] fit_type(input logic [2:0] t, input logic [31:0] v);
        logic [31:0] r;
        r = v;
        unique case (t)
            TYPE_SIGNED_16:   r = {{16{v[15]}}, v[15:0]};
            TYPE_UNSIGNED_8:  r = {24'h00_0000, v[7:0]};
            TYPE_UNSIGNED_16: r = {16'h0000, v[15:0]};
            default:          r = v;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] info_word(input int i);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[INFO_RO_BIT]  = PAR_READ_ONLY[i];
        r[INFO_RE_BIT]  = PAR_POWER_CYCLE[i];
        r[INFO_RUN_BIT] = PAR_CHG_RUN[i];
        r[INFO_RDY_BIT] = PAR_CHG_READY[i];
        r[INFO_TYPE_LSB +: 3]  = PAR_TYPE[i];
        r[INFO_GROUP_LSB +: 3] = PAR_GROUP[i];
        return r;
    endfunction

    // Returns {hit, word}; a miss answers an error with zero data
    function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a, input dps_state_type st,
                                               input logic run, input logic rdy);
        logic [32:0] r;
        logic [2:0]  idx;
        logic [31:0] stat;
        r    = 33'h0_0000_0000;
        idx  = a[4:2];
        stat = 32'h0000_0000;
        stat[STAT_RUNNING_BIT] = run;
        stat[STAT_READY_BIT]   = rdy;
        stat[STAT_REJECT_LSB +: 16] = st.reject_cnt;
        if (a == OFS_OUT_INVERT_MASK) begin
            r = {1'b1, 26'h000_0000, st.out_invert_mask};
        end else if (a == OFS_INPUT_SIM_SELECT) begin
            r = {1'b1, 22'h00_0000, st.input_sim_select};
        end else if (a == OFS_INPUT_SIM_VALUE) begin
            r = {1'b1, 22'h00_0000, st.input_sim_value};
        end else if (a == OFS_DRIVE_STATUS) begin
            r = {1'b1, stat};
        end else if (a[1:0] == 2'b00) begin
            unique case (a[7:5])
                REGION_PARAM_STORED: begin
                    // Status entries show live state instead of storage
                    if (idx == 3'h6) begin
                        r = {1'b1, 22'h00_0000, st.di_eff};
                    end else if (idx == 3'h7) begin
                        r = {1'b1, 16'h0000, st.reject_cnt};
                    end else begin
                        r = {1'b1, st.stored[idx]};
                    end
                end
                REGION_PARAM_ACTIVE: r = {1'b1, st.active[idx]};
                REGION_PARAM_INFO:   r = {1'b1, info_word(int'(idx))};
                default:             r = 33'h0_0000_0000;
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        wr_do     = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        wr_idx    = s_q.aw_addr[4:2];
        wr_region = s_q.aw_addr[7:5];
        wr_bmask  = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        wr_look   = read_word(s_q.aw_addr, s_q, drive_running, drive_ready);
        wr_old    = wr_look[31:0];
        wr_merged = (wr_old & ~wr_bmask) | (s_q.w_data & wr_bmask);
        // Fixed registers change in either running or ready state
        fix_chg   = drive_running || drive_ready;
        wr_ok     = 1'b0;
        rd_look   = read_word(s_axi_araddr, s_q, drive_running, drive_ready);

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Write decision, one per completed address and data pair
        if (wr_do) begin
            if (s_q.aw_addr == OFS_OUT_INVERT_MASK) begin
                wr_ok = fix_chg;
                if (wr_ok) begin
                    s_d.out_invert_mask = wr_merged[5:0];
                end
            end else if (s_q.aw_addr == OFS_INPUT_SIM_SELECT) begin
                // A whole write is refused if it would simulate a safety input
                wr_ok = fix_chg && ((wr_merged[9:0] & safe_torque_off_src) == 10'h000);
                if (wr_ok) begin
                    s_d.input_sim_select = wr_merged[9:0];
                end
            end else if (s_q.aw_addr == OFS_INPUT_SIM_VALUE) begin
                wr_ok = fix_chg;
                if (wr_ok) begin
                    s_d.input_sim_value = wr_merged[9:0];
                end
            end else if (wr_region == REGION_PARAM_STORED && s_q.aw_addr[1:0] == 2'b00) begin
                wr_ok = !PAR_READ_ONLY[wr_idx]
                     && ((PAR_CHG_RUN[wr_idx] && drive_running)
                     ||  (PAR_CHG_READY[wr_idx] && drive_ready));
                if (wr_ok) begin
                    s_d.stored[wr_idx] = fit_type(PAR_TYPE[wr_idx], wr_merged);
                    if (!PAR_POWER_CYCLE[wr_idx]) begin
                        s_d.active[wr_idx] = s_d.stored[wr_idx];
                    end
                end
            end
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (!wr_ok) begin
                s_d.reject_cnt = s_q.reject_cnt + 16'h0001;
            end
        end

        // Pending power-cycle values go live only on the power-on event
        if (power_on_load) begin
            for (int i = 0; i < NPAR; i++) begin
                if (PAR_POWER_CYCLE[i]) begin
                    s_d.active[i] = s_d.stored[i];
                end
            end
        end

        // Read channel: answer one cycle after the address is taken
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_look[31:0];
            s_d.rresp  = rd_look[32] ? RESP_OKAY : RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready  = !s_d.w_got && !s_d.bvalid;

        // Terminal conditioning; safety inputs always follow the terminal
        sim_eff    = s_q.input_sim_select & ~safe_torque_off_src;
        s_d.di_eff = (sim_eff & s_q.input_sim_value) | (~sim_eff & input_line_pin);
        s_d.do_out = output_line_func ^ s_q.out_invert_mask;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q                  <= '0;
            s_q.awready          <= 1'b1;
            s_q.wready           <= 1'b1;
            s_q.arready          <= 1'b1;
            s_q.out_invert_mask  <= OUT_INVERT_RST;
            s_q.input_sim_select <= SIM_SELECT_RST;
            s_q.input_sim_value  <= SIM_VALUE_RST;
            s_q.stored           <= PAR_DEFAULT;
            s_q.active           <= PAR_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready   = s_q.awready;
    assign s_axi_wready    = s_q.wready;
    assign s_axi_bvalid    = s_q.bvalid;
    assign s_axi_bresp     = s_q.bresp;
    assign s_axi_arready   = s_q.arready;
    assign s_axi_rvalid    = s_q.rvalid;
    assign s_axi_rdata     = s_q.rdata;
    assign s_axi_rresp     = s_q.rresp;
    assign input_line_func = s_q.di_eff;
    assign output_line_pin = s_q.do_out;
    assign param_value     = s_q.active;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence answer_ok;
        ##1 (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
    endsequence

    sequence answer_err;
        ##1 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    endsequence

    logic param_wr;
    assign param_wr = wr_do && wr_region == REGION_PARAM_STORED && s_q.aw_addr[1:0] == 2'b00;

    ro_refused_a: assert property (param_wr && PAR_READ_ONLY[wr_idx]
        |-> answer_err ##0 (s_q.stored == $past(s_q.stored)))
        else $error("read-only parameter accepted a write");

    im_apply_a: assert property (param_wr && wr_ok && !PAR_POWER_CYCLE[wr_idx]
        |=> s_q.active[$past(wr_idx)] == s_q.stored[$past(wr_idx)])
        else $error("immediate parameter not applied after write");

    re_hold_a: assert property (param_wr && wr_ok && PAR_POWER_CYCLE[wr_idx] && !power_on_load
        |=> s_q.active[$past(wr_idx)] == $past(s_q.active[wr_idx]))
        else $error("power-cycle parameter applied before power-on");

    run_accept_a: assert property (param_wr && !PAR_READ_ONLY[wr_idx]
        && PAR_CHG_RUN[wr_idx] && drive_running |-> answer_ok)
        else $error("run-class write refused while running");

    ready_accept_a: assert property (param_wr && !PAR_READ_ONLY[wr_idx]
        && PAR_CHG_READY[wr_idx] && drive_ready |-> answer_ok)
        else $error("ready-class write refused while ready");

    type_fit_a: assert property (param_wr && wr_ok && PAR_TYPE[wr_idx] == TYPE_UNSIGNED_8
        |=> s_q.stored[$past(wr_idx)][31:8] == 24'h00_0000)
        else $error("unsigned 8 parameter stored too wide");

    // Attempts start only out of reset, so the reset-held outputs are never compared
    invert_out_a: assert property (aresetn |=> output_line_pin
        == ($past(output_line_func) ^ $past(s_q.out_invert_mask)))
        else $error("output inversion mismatch");

    sim_route_a: assert property (aresetn |=> input_line_func
        == (($past(sim_eff) & $past(s_q.input_sim_value)) | (~$past(sim_eff) & $past(input_line_pin))))
        else $error("input routing mismatch");

    sto_reject_a: assert property (wr_do && s_q.aw_addr == OFS_INPUT_SIM_SELECT
        && (wr_merged[9:0] & safe_torque_off_src) != 10'h000
        |-> answer_err ##0 (s_q.input_sim_select == $past(s_q.input_sim_select)))
        else $error("simulation allowed on a safety input");

    state_reject_a: assert property (param_wr && !drive_running && !drive_ready
        |-> answer_err ##0 (s_q.reject_cnt == $past(s_q.reject_cnt) + 16'h0001))
        else $error("write accepted with no valid drive state");

endmodule // dps_param_store

`default_nettype wire

// ===== tb/dps_term_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Terminal side: input levels and output sampling
// ------------------------------------------------------------------
module dps_term_model
    import dps_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic [DI_N-1:0]   level_set,
    input  wire logic [DO_N-1:0]   output_line_pin,
    output var  logic [DI_N-1:0]   input_line_pin,
    output var  logic [DO_N-1:0]   seen_out
);
    // Terminals follow the wiring at once; outputs are latched like a slow reader
    always_comb input_line_pin = level_set;
    always_ff @(posedge aclk) seen_out <= output_line_pin;
endmodule // dps_term_model

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import dps_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rd_r;
    logic        drive_running, drive_ready, power_on_load;
    logic [9:0]  sto_src, level_set, pin, func;
    logic [5:0]  out_func, out_pin, seen_out;
    logic [255:0] param_value;
    int          error_cnt, compares;

    dps_param_store dps_param_store_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .drive_running(drive_running), .drive_ready(drive_ready), .power_on_load(power_on_load),
        .safe_torque_off_src(sto_src), .input_line_pin(pin), .input_line_func(func),
        .output_line_func(out_func), .output_line_pin(out_pin), .param_value(param_value));
    dps_term_model dps_term_model_inst (.aclk(aclk), .level_set(level_set), .output_line_pin(out_pin),
        .input_line_pin(pin), .seen_out(seen_out));

    // ------------------------------------------------------------------
    // Clock, time-zero values and watchdog
    // ------------------------------------------------------------------
    initial begin
        aclk = 0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, drive_running, drive_ready, power_on_load} = 0;
        {awaddr, araddr, wdata, sto_src, level_set, out_func} = 0;
        wstrb = 4'hf;
        error_cnt = 0;
        compares = 0;
    end
    // Far above the roughly 120 cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1) begin aw_done = 1; awvalid <= 0; end
            if (!w_done && wready === 1) begin w_done = 1; wvalid <= 0; end
        end
        // Response ready is driven high again by each call and never lowered, so back-to-back calls take each response at once
        do @(posedge aclk); while (bvalid !== 1);
        chk("bresp", er, bresp);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1);
        rd_d = rdata;
        rd_r = rresp;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, exp, rd_d);
    endtask
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NPAR; i++) begin
            rchk("active", 8'h60 + 8'(4 * i), PAR_DEFAULT[i]);
            rchk("info", 8'h80 + 8'(4 * i), {21'h0, PAR_GROUP[i], 1'b0, PAR_TYPE[i], PAR_CHG_READY[i],
                PAR_CHG_RUN[i], PAR_POWER_CYCLE[i], PAR_READ_ONLY[i]});
        end
        rchk("mask", OFS_OUT_INVERT_MASK, 32'h0);
    endtask
    task automatic t_readonly();
        drive_ready <= 1;
        wr(8'h58, 32'h5, RESP_SLVERR);
        wr(OFS_DRIVE_STATUS, 32'h5, RESP_SLVERR);
        rd(8'hfc);
        chk("rresp", RESP_SLVERR, {30'h0, rd_r});
        rchk("status", OFS_DRIVE_STATUS, 32'h0002_0002);
    endtask
    task automatic t_state();
        drive_running <= 1;
        drive_ready <= 0;
        wr(8'h4c, 32'h8001, RESP_SLVERR);
        rchk("entry3", 8'h6c, 32'h64);
        drive_running <= 0;
        drive_ready <= 1;
        wr(8'h4c, 32'h8001, RESP_OKAY);
        rchk("entry3", 8'h6c, 32'hffff_8001);
        chk("pv3", 32'hffff_8001, param_value[127:96]);
        drive_running <= 1;
        drive_ready <= 0;
        wr(8'h44, 32'hdead_beef, RESP_OKAY);
        chk("pv1", 32'hdead_beef, param_value[63:32]);
        drive_running <= 0;
        drive_ready <= 0;
        wr(8'h40, 32'h5, RESP_SLVERR);
        rchk("entry0", 8'h40, 32'h0);
    endtask
    // Pending value must wait for the power-on pulse
    task automatic t_power();
        drive_running <= 0;
        drive_ready <= 1;
        wr(8'h48, 32'h1234, RESP_OKAY);
        rchk("entry2", 8'h68, 32'h7d0);
        wr(8'h50, 32'h1ff, RESP_OKAY);
        rchk("entry4", 8'h50, 32'hff);
        power_on_load <= 1;
        @(posedge aclk);
        power_on_load <= 0;
        repeat (2) @(posedge aclk);
        rchk("entry2", 8'h68, 32'h1234);
        chk("pv4", 32'hff, param_value[159:128]);
    endtask
    task automatic t_io();
        wr(OFS_OUT_INVERT_MASK, 32'h2a, RESP_OKAY);
        out_func <= 6'h3f;
        repeat (3) @(posedge aclk);
        chk("outpin", 32'h15, {26'h0, seen_out});
        level_set <= 10'h3ff;
        wr(OFS_INPUT_SIM_VALUE, 32'h155, RESP_OKAY);
        wr(OFS_INPUT_SIM_SELECT, 32'h0f0, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("infunc", 32'h35f, {22'h0, func});
        sto_src <= 10'h020;
        wr(OFS_INPUT_SIM_SELECT, 32'h020, RESP_SLVERR);
        rchk("select", OFS_INPUT_SIM_SELECT, 32'h0f0);
        chk("infunc", 32'h37f, {22'h0, func});
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_readonly();
        t_state();
        t_power();
        t_io();
        close_out();
    end
endmodule // tb

`default_nettype wire
